/* File: inc/sbc_pkg.sv */
// Purpose: Shared constants and carriers for the digital audio buffer control register slice.
// Assumes: Byte-wide host register port with 7-bit addresses.
// Notes:   Offsets are the host register addresses of the slice.
package sbc_pkg;
  localparam int unsigned ADDR_W = 7;
  localparam int unsigned DATA_W = 8;

  // Register addresses.
  localparam logic [6:0] ADDR_STATUS_SWITCH = 7'h0E;
  localparam logic [6:0] ADDR_MSG_GAP_HIGH  = 7'h0F;
  localparam logic [6:0] ADDR_MSG_GAP_LOW   = 7'h10;
  localparam logic [6:0] ADDR_AUTOFORWARD   = 7'h11;
  localparam logic [6:0] ADDR_RATIO_HIGH    = 7'h12;
  localparam logic [6:0] ADDR_RATIO_LOW     = 7'h13;
  localparam logic [6:0] ADDR_PRE_C_HIGH    = 7'h14;
  localparam logic [6:0] ADDR_PRE_C_LOW     = 7'h15;
  localparam logic [6:0] ADDR_PRE_D_HIGH    = 7'h16;
  localparam logic [6:0] ADDR_PRE_D_LOW     = 7'h17;
  localparam logic [6:0] ADDR_RX_CS_FIRST   = 7'h20;
  localparam logic [6:0] ADDR_RX_CS_LAST    = 7'h37;
  localparam logic [6:0] ADDR_TX_CS_FIRST   = 7'h38;
  localparam logic [6:0] ADDR_TX_CS_LAST    = 7'h4F;

  // Field positions.
  localparam int unsigned BIT_RX_PAGE     = 0;
  localparam int unsigned BIT_TX_PAGE     = 1;
  localparam int unsigned BIT_COPY_INHIB  = 4;
  localparam int unsigned BIT_AB_SHARED   = 5;
  localparam int unsigned BIT_CS_FORWARD  = 4;
  localparam int unsigned BIT_UB_FORWARD  = 5;
  localparam int unsigned BIT_GAP_ADJUST  = 6;

  // Implemented bit masks; all other bits are reserved.
  localparam logic [7:0] MASK_STATUS_SWITCH = 8'h33;
  localparam logic [7:0] MASK_AUTOFORWARD   = 8'h7F;
  localparam logic [7:0] MASK_RATIO_HIGH    = 8'h7F;

  // Reset values and the unit gap saturation limit.
  localparam logic [7:0] RST_STATUS_SWITCH = 8'h00;
  localparam logic [7:0] RST_MSG_GAP_HIGH  = 8'h00;
  localparam logic [7:0] RST_MSG_GAP_LOW   = 8'h09;
  localparam logic [7:0] RST_AUTOFORWARD   = 8'h00;
  localparam logic [3:0] UNIT_GAP_LIMIT    = 4'h8;
  localparam logic [7:0] ZERO_BYTE         = 8'h00;

  // Control outputs presented to the transmitter and receiver datapaths.
  typedef struct packed {
    logic        ab_shared;
    logic        copy_inhibit;
    logic        tx_page;
    logic        rx_page;
    logic        gap_adjust;
    logic        user_fwd;
    logic        status_fwd;
    logic [3:0]  unit_gap_max;
    logic [15:0] message_gap;
  } sbc_ctrl_s;

  // Read-only observations from the receiver and rate converter.
  typedef struct packed {
    logic        nonaudio;
    logic        subframe_mode;
    logic [14:0] rate_ratio;
    logic [15:0] pre_c;
    logic [15:0] pre_d;
    logic [15:0] pre_c_b;
  } sbc_stat_s;
endpackage : sbc_pkg

/* File: rtl/sbc_status_page.sv */
// Purpose: Dual-page 24-byte channel status buffer with host and datapath ports.
// Assumes: Host index is 0..23; the datapath reads one byte at a time.
// Notes:   Shared mode redirects datapath page B reads to page A; host reads still see page B.
`timescale 1ns/100ps
module sbc_status_page
  import sbc_pkg::*;
#(
  parameter int unsigned DEPTH = 24
)
(
  input  wire logic       mclk,
  input  wire logic       rstn,
  input  wire logic       host_page,
  input  wire logic [4:0] host_idx,
  input  wire logic       host_we,
  input  wire logic [7:0] host_wdata,
  output logic      [7:0] host_rdata,
  input  wire logic       dp_we,
  input  wire logic       dp_page,
  input  wire logic [4:0] dp_idx,
  input  wire logic [7:0] dp_wdata,
  input  wire logic       shared,
  input  wire logic [4:0] dp_ridx,
  input  wire logic       dp_rpage,
  output logic      [7:0] dp_rdata
);
  logic [7:0] mem_a [DEPTH];
  logic [7:0] mem_b [DEPTH];
  logic       rpage_eff;

  // Host writes take priority; a datapath write in the same cycle is dropped, whatever its cell.
  always_ff @(posedge mclk)
  begin
    if (!rstn)
    begin
      for (int i = 0; i < DEPTH; i++)
      begin
        mem_a[i] <= ZERO_BYTE;
        mem_b[i] <= ZERO_BYTE;
      end
    end
    else if (host_we)
    begin
      if (host_page) mem_b[host_idx] <= host_wdata;
      else           mem_a[host_idx] <= host_wdata;
    end
    else if (dp_we)
    begin
      if (dp_page) mem_b[dp_idx] <= dp_wdata;
      else         mem_a[dp_idx] <= dp_wdata;
    end
  end

  // Host view of the selected page.
  always_comb
  begin
    host_rdata = host_page ? mem_b[host_idx] : mem_a[host_idx];
  end

  // Datapath view; shared mode sources both subframes from page A.
  assign rpage_eff = dp_rpage & ~shared;

  always_ff @(posedge mclk)
  begin
    if (!rstn) dp_rdata <= ZERO_BYTE;
    else       dp_rdata <= rpage_eff ? mem_b[dp_ridx] : mem_a[dp_ridx];
  end
endmodule : sbc_status_page

/* File: rtl/sbc_regs.sv */
// Purpose: Host register slice for channel status switching, zero stuffing and autobuffering.
// Assumes: Host port is a byte-wide synchronous strobe interface behind the serial controller.
// Notes:   Read data is registered and valid the cycle after the read strobe.
`timescale 1ns/100ps
// Behaviour
// - Shared mode makes transmitter datapath page B reads return status A.
// - Copy inhibit stops status into transmitter frame.
// - Transmit page bit maps A/B at 0x38-0x4F.
// - Receive page bit maps A/B at 0x20-0x37.
// - 0x0F holds message gap high, reset zero.
// - 0x10 holds message gap low, reset nine.
// - Gap adjust bit permits unit gap changes.
// - User forward bit passes user bits through.
// - Status forward bit passes channel status through.
// - Unit gap field limits zeros, max eight.
// - Read-only 15-bit rate ratio at 0x12/0x13.
// - Preamble C reads at 0x14/0x15, else zero.
// - 0x16 reads preamble D high, else zero.
// - Subframe mode puts B preamble C at 0x16.
// - 0x17 reads preamble D low, else zero.
module sbc_regs
  import sbc_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        rstn,
  input  wire logic        host_wr,
  input  wire logic        host_rd,
  input  wire logic [6:0]  host_addr,
  input  wire logic [7:0]  host_wdata,
  output logic      [7:0]  host_rdata,
  output logic             host_rvalid,
  input  wire sbc_stat_s   stat,
  input  wire logic        rx_cs_we,
  input  wire logic        rx_cs_page,
  input  wire logic [4:0]  rx_cs_idx,
  input  wire logic [7:0]  rx_cs_wdata,
  input  wire logic [4:0]  tx_cs_ridx,
  input  wire logic        tx_cs_rpage,
  input  wire logic        tx_cs_rreq,
  output logic      [7:0]  tx_cs_rdata,
  output logic             tx_cs_load,
  output sbc_ctrl_s        ctrl
);
  logic [7:0] switch_r;
  logic [7:0] gap_high_r;
  logic [7:0] gap_low_r;
  logic [7:0] autofwd_r;
  logic [7:0] rdata_nxt;
  logic [7:0] rx_host_rdata;
  logic [7:0] tx_host_rdata;
  logic [7:0] tx_dp_rdata;
  logic [7:0] rx_dp_rdata;
  logic [4:0] rx_idx;
  logic [4:0] tx_idx;
  logic       in_rx;
  logic       in_tx;
  logic       fwd_we;
  logic       tx_load_r;
  logic [3:0] gap_field;

  // Address windows of the two paged buffers.
  assign in_rx  = (host_addr >= ADDR_RX_CS_FIRST) && (host_addr <= ADDR_RX_CS_LAST);
  assign in_tx  = (host_addr >= ADDR_TX_CS_FIRST) && (host_addr <= ADDR_TX_CS_LAST);
  assign rx_idx = 5'(host_addr - ADDR_RX_CS_FIRST);
  assign tx_idx = 5'(host_addr - ADDR_TX_CS_FIRST);

  // Status switch register; reserved bits are masked out.
  always_ff @(posedge mclk)
  begin
    if (!rstn)
      switch_r <= RST_STATUS_SWITCH;
    else if (host_wr && host_addr == ADDR_STATUS_SWITCH)
      switch_r <= host_wdata & MASK_STATUS_SWITCH;
  end

  // Message gap count, high and low bytes.
  always_ff @(posedge mclk)
  begin
    if (!rstn)
    begin
      gap_high_r <= RST_MSG_GAP_HIGH;
      gap_low_r  <= RST_MSG_GAP_LOW;
    end
    else if (host_wr && host_addr == ADDR_MSG_GAP_HIGH)
      gap_high_r <= host_wdata;
    else if (host_wr && host_addr == ADDR_MSG_GAP_LOW)
      gap_low_r  <= host_wdata;
  end

  // Autoforward control; bit 7 is reserved.
  always_ff @(posedge mclk)
  begin
    if (!rstn)
      autofwd_r <= RST_AUTOFORWARD;
    else if (host_wr && host_addr == ADDR_AUTOFORWARD)
      autofwd_r <= host_wdata & MASK_AUTOFORWARD;
  end

  // Unit gap limit saturates at eight so larger codes cannot overstuff.
  assign gap_field = (autofwd_r[3:0] > UNIT_GAP_LIMIT) ? UNIT_GAP_LIMIT
                                                       : autofwd_r[3:0];

  // Control outputs to the transmitter and receiver datapaths.
  always_comb
  begin
    ctrl              = '0;
    ctrl.ab_shared    = switch_r[BIT_AB_SHARED];
    ctrl.copy_inhibit = switch_r[BIT_COPY_INHIB];
    ctrl.tx_page      = switch_r[BIT_TX_PAGE];
    ctrl.rx_page      = switch_r[BIT_RX_PAGE];
    ctrl.gap_adjust   = autofwd_r[BIT_GAP_ADJUST];
    ctrl.user_fwd     = autofwd_r[BIT_UB_FORWARD];
    ctrl.status_fwd   = autofwd_r[BIT_CS_FORWARD];
    ctrl.unit_gap_max = autofwd_r[BIT_GAP_ADJUST] ? gap_field : 4'h0;
    ctrl.message_gap  = {gap_high_r, gap_low_r};
  end

  // Receive channel status buffer, written by the receiver datapath.
  sbc_status_page u_rx_page (
    .mclk       (mclk),
    .rstn       (rstn),
    .host_page  (switch_r[BIT_RX_PAGE]),
    .host_idx   (rx_idx),
    .host_we    (1'b0),
    .host_wdata (host_wdata),
    .host_rdata (rx_host_rdata),
    .dp_we      (rx_cs_we),
    .dp_page    (rx_cs_page),
    .dp_idx     (rx_cs_idx),
    .dp_wdata   (rx_cs_wdata),
    .shared     (1'b0),
    .dp_ridx    (rx_cs_idx),
    .dp_rpage   (rx_cs_page),
    .dp_rdata   (rx_dp_rdata)
  );

  // Status forwarding copies received bytes straight into the transmit buffer.
  assign fwd_we = rx_cs_we & autofwd_r[BIT_CS_FORWARD];

  // Transmit channel status buffer, host writable.
  sbc_status_page u_tx_page (
    .mclk       (mclk),
    .rstn       (rstn),
    .host_page  (switch_r[BIT_TX_PAGE]),
    .host_idx   (tx_idx),
    .host_we    (host_wr & in_tx),
    .host_wdata (host_wdata),
    .host_rdata (tx_host_rdata),
    .dp_we      (fwd_we),
    .dp_page    (rx_cs_page),
    .dp_idx     (rx_cs_idx),
    .dp_wdata   (rx_cs_wdata),
    .shared     (switch_r[BIT_AB_SHARED]),
    .dp_ridx    (tx_cs_ridx),
    .dp_rpage   (tx_cs_rpage),
    .dp_rdata   (tx_dp_rdata)
  );

  // Transfer into the transmitter frame buffer is gated by copy inhibit.
  always_ff @(posedge mclk)
  begin
    if (!rstn)
      tx_load_r <= 1'b0;
    else
      tx_load_r <= tx_cs_rreq & ~switch_r[BIT_COPY_INHIB];
  end

  assign tx_cs_load  = tx_load_r;
  assign tx_cs_rdata = tx_dp_rdata;

  // Read multiplexer; unmapped and reserved bits return zero.
  always_comb
  begin
    rdata_nxt = ZERO_BYTE;
    if (host_addr == ADDR_STATUS_SWITCH)
      rdata_nxt = switch_r;
    else if (host_addr == ADDR_MSG_GAP_HIGH)
      rdata_nxt = gap_high_r;
    else if (host_addr == ADDR_MSG_GAP_LOW)
      rdata_nxt = gap_low_r;
    else if (host_addr == ADDR_AUTOFORWARD)
      rdata_nxt = autofwd_r;
    else if (host_addr == ADDR_RATIO_HIGH)
      rdata_nxt = {1'b0, stat.rate_ratio[14:8]} & MASK_RATIO_HIGH;
    else if (host_addr == ADDR_RATIO_LOW)
      rdata_nxt = stat.rate_ratio[7:0];
    else if (host_addr == ADDR_PRE_C_HIGH)
      rdata_nxt = stat.nonaudio ? stat.pre_c[15:8] : ZERO_BYTE;
    else if (host_addr == ADDR_PRE_C_LOW)
      rdata_nxt = stat.nonaudio ? stat.pre_c[7:0] : ZERO_BYTE;
    else if (host_addr == ADDR_PRE_D_HIGH)
    begin
      if (!stat.nonaudio)
        rdata_nxt = ZERO_BYTE;
      else if (stat.subframe_mode)
        rdata_nxt = stat.pre_c_b[15:8];
      else
        rdata_nxt = stat.pre_d[15:8];
    end
    else if (host_addr == ADDR_PRE_D_LOW)
      rdata_nxt = stat.nonaudio ? stat.pre_d[7:0] : ZERO_BYTE;
    else if (in_rx)
      rdata_nxt = rx_host_rdata;
    else if (in_tx)
      rdata_nxt = tx_host_rdata;
  end

  // Registered read data.
  always_ff @(posedge mclk)
  begin
    if (!rstn)
    begin
      host_rdata  <= ZERO_BYTE;
      host_rvalid <= 1'b0;
    end
    else
    begin
      host_rvalid <= host_rd;
      if (host_rd)
        host_rdata <= rdata_nxt;
    end
  end
endmodule : sbc_regs

/* File: dv/sbc_regs_properties.sv */
// Purpose: Port assertions for the buffer control register slice.
// Assumes: One clock domain with a synchronous active-low reset.
// Notes:   Bound to every instance of the slice.
`timescale 1ns/100ps
module sbc_regs_chk
  import sbc_pkg::*;
(
  input wire logic       mclk,
  input wire logic       rstn,
  input wire logic       host_wr,
  input wire logic       host_rd,
  input wire logic [6:0] host_addr,
  input wire logic [7:0] host_wdata,
  input wire logic [7:0] host_rdata,
  input wire logic       host_rvalid,
  input wire sbc_stat_s  stat,
  input wire logic       tx_cs_rreq,
  input wire logic       tx_cs_load,
  input wire sbc_ctrl_s  ctrl
);
  // All checks sample on the rising clock and sleep during reset.
  default clocking dc @(posedge mclk); endclocking
  default disable iff (!rstn);

  a_read_answer: assert property (host_rvalid == $past(host_rd))
    else $error("read answer out of step");
  a_gap_reset: assert property ($rose(rstn) |-> ctrl.message_gap == 16'h0009)
    else $error("message gap reset wrong");
  a_adjust_off: assert property (!ctrl.gap_adjust |-> ctrl.unit_gap_max == 4'h0)
    else $error("unit gap without adjust");
  a_switch_write: assert property (host_wr && host_addr == 7'h0E |=> {ctrl.ab_shared,
    ctrl.copy_inhibit, ctrl.tx_page, ctrl.rx_page} == $past({host_wdata[5:4], host_wdata[1:0]}))
    else $error("switch bits not taken");
  a_fwd_write: assert property (host_wr && host_addr == 7'h11 |=> {ctrl.gap_adjust,
    ctrl.user_fwd, ctrl.status_fwd} == $past(host_wdata[6:4]))
    else $error("forward bits not taken");
  a_load_inhibit: assert property (tx_cs_rreq |=> tx_cs_load == !$past(ctrl.copy_inhibit))
    else $error("load ignores inhibit");
  a_ratio_view: assert property (host_rd && host_addr == 7'h12 |=>
    host_rdata == {1'b0, $past(stat.rate_ratio[14:8])})
    else $error("ratio high wrong");
  a_pre_d_view: assert property (host_rd && host_addr == 7'h16 |=> host_rdata ==
    (!$past(stat.nonaudio) ? 8'h00 : $past(stat.subframe_mode) ?
    $past(stat.pre_c_b[15:8]) : $past(stat.pre_d[15:8])))
    else $error("preamble d high wrong");
endmodule : sbc_regs_chk

bind sbc_regs sbc_regs_chk u_chk (
  .mclk        (mclk),
  .rstn        (rstn),
  .host_wr     (host_wr),
  .host_rd     (host_rd),
  .host_addr   (host_addr),
  .host_wdata  (host_wdata),
  .host_rdata  (host_rdata),
  .host_rvalid (host_rvalid),
  .stat        (stat),
  .tx_cs_rreq  (tx_cs_rreq),
  .tx_cs_load  (tx_cs_load),
  .ctrl        (ctrl)
);

/* File: dv/sbc_far_model.sv */
// Purpose: Receiver and rate converter side feeding observations to the slice.
// Assumes: Preamble fields mean nothing while no burst is detected.
// Notes:   Those fields then toggle every cycle, so stale values cannot pass.
`timescale 1ns/100ps
module sbc_far_model
  import sbc_pkg::*;
(
  input  wire logic mclk,
  input  wire logic nonaudio,
  input  wire logic subframe_mode,
  output sbc_stat_s stat
);
  logic [15:0] junk_r = 16'hA55A;

  // Meaningless preamble content changes every cycle.
  always_ff @(posedge mclk)
    junk_r <= ~junk_r;

  // Observation bundle with fixed ratio; preambles are fixed only while nonaudio is set.
  assign stat = {nonaudio, subframe_mode, 15'h5A3C, nonaudio ? 16'hC1C2 : junk_r,
                 nonaudio ? 16'hD1D2 : ~junk_r, nonaudio ? 16'hB1B2 : junk_r};
endmodule : sbc_far_model

/* File: dv/test_spdif_buffer_control_regs.sv */
// Purpose: Self-checking bench for the buffer control register slice.
// Assumes: All inputs change at falling clock edges.
// Notes:   One idle cycle follows every access to keep strobes clean.
`timescale 1ns/100ps
module test_spdif_buffer_control_regs
  import sbc_pkg::*;
;
  logic       mclk = 0, rstn = 0, host_wr = 0, host_rd = 0, nonaudio = 0;
  logic       subframe_mode = 0, rx_cs_we = 0, rx_cs_page = 0, tx_cs_rpage = 0;
  logic       tx_cs_rreq = 0, host_rvalid, tx_cs_load;
  logic [6:0] host_addr = 0;
  logic [7:0] host_wdata = 0, rx_cs_wdata = 0, host_rdata, tx_cs_rdata;
  logic [4:0] rx_cs_idx = 0, tx_cs_ridx = 0;
  sbc_stat_s  stat;
  sbc_ctrl_s  ctrl;
  int         n_mismatch = 0, check_count = 0;

  sbc_regs dut (.*);
  sbc_far_model far (.*);

  // Free-running 125 MHz clock.
  initial
  begin
    forever #4 mclk = ~mclk;
  end

  task automatic finish_test();
    if (n_mismatch == 0 && check_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : finish_test

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    host_addr = a;
    host_wdata = d;
    host_wr = 1;
    @(negedge mclk) host_wr = 0;
    @(negedge mclk);
  endtask : wr

  task automatic rd(input logic [6:0] a, input logic [7:0] e);
    host_addr = a;
    host_rd = 1;
    @(negedge mclk) host_rd = 0;
    chk(16'(host_rvalid), 16'h1);
    chk(16'(host_rdata), 16'(e));
    @(negedge mclk);
  endtask : rd

  task automatic rxw(input logic p, input logic [4:0] i, input logic [7:0] d);
    rx_cs_page = p;
    rx_cs_idx = i;
    rx_cs_wdata = d;
    rx_cs_we = 1;
    @(negedge mclk) rx_cs_we = 0;
    @(negedge mclk);
  endtask : rxw

  task automatic txr(input logic p, input logic [4:0] i, input logic [7:0] e,
                     input logic ld);
    tx_cs_rpage = p;
    tx_cs_ridx = i;
    tx_cs_rreq = 1;
    @(negedge mclk) tx_cs_rreq = 0;
    chk(16'(tx_cs_rdata), 16'(e));
    chk(16'(tx_cs_load), 16'(ld));
    @(negedge mclk);
  endtask : txr

  // Main sequence: defaults, fields, read-only views, then the buffers.
  initial
  begin
    repeat (8) @(negedge mclk);
    rstn = 1;
    rd(7'h0E, 8'h00);
    rd(7'h0F, 8'h00);
    rd(7'h10, 8'h09);
    rd(7'h11, 8'h00);
    wr(7'h0F, 8'hA5);
    wr(7'h10, 8'h3C);
    chk(ctrl.message_gap, 16'hA53C);
    wr(7'h11, 8'hFF);
    rd(7'h11, 8'h7F);
    chk(16'({ctrl.user_fwd, ctrl.status_fwd}), 16'h3);
    for (int i = 0; i < 9; i++)
    begin
      wr(7'h11, 8'(8'h40 + i));
      chk(16'(ctrl.unit_gap_max), 16'(i));
    end
    wr(7'h11, 8'h4F);
    chk(16'(ctrl.unit_gap_max), 16'h8);
    rd(7'h11, 8'h4F);
    wr(7'h11, 8'h08);
    chk(16'(ctrl.unit_gap_max), 16'h0);
    wr(7'h0E, 8'hFF);
    rd(7'h0E, 8'h33);
    wr(7'h13, 8'hFF);
    rd(7'h13, 8'h3C);
    rd(7'h12, 8'h5A);
    for (int a = 20; a < 24; a++)
      rd(7'(a), 8'h00);
    nonaudio = 1;
    rd(7'h14, 8'hC1);
    rd(7'h15, 8'hC2);
    rd(7'h16, 8'hD1);
    rd(7'h17, 8'hD2);
    subframe_mode = 1;
    rd(7'h16, 8'hB1);
    wr(7'h0E, 8'h00);
    wr(7'h38, 8'h11);
    wr(7'h0E, 8'h02);
    wr(7'h38, 8'h22);
    rd(7'h38, 8'h22);
    txr(0, 0, 8'h11, 1);
    txr(1, 0, 8'h22, 1);
    wr(7'h0E, 8'h20);
    txr(1, 0, 8'h11, 1);
    wr(7'h0E, 8'h10);
    txr(0, 0, 8'h11, 0);
    rxw(1, 0, 8'h5A);
    wr(7'h0E, 8'h01);
    rd(7'h20, 8'h5A);
    wr(7'h0E, 8'h00);
    rd(7'h20, 8'h00);
    wr(7'h11, 8'h10);
    rxw(0, 1, 8'h77);
    txr(0, 1, 8'h77, 1);
    wr(7'h11, 8'h00);
    rxw(0, 2, 8'h66);
    txr(0, 2, 8'h00, 1);
    rd(7'h7F, 8'h00);
    finish_test();
  end

  // Watchdog: the sequence needs well under 1000 cycles.
  initial
  begin
    #200000;
    n_mismatch++;
    finish_test();
  end
endmodule : test_spdif_buffer_control_regs
